// ### src/oam_core.sv
`timescale 1ns/100ps
`include "oam_consts.svh"

// What this block does
// - Direct-immediate mode: operand one is result address, operand two the value.
// - Arithmetic there reads second source at operand one; three bytes long.
// - Indexed-immediate mode: result address is operand one plus index register.
// - Arithmetic there reads second source at indexed address; three bytes long.
// - Memory copy: RAM at operand two copied to RAM at operand one.
// - Memory copy form only for copy op; three bytes long.
// - Indirect source post-increment writes its result to the accumulator.
// - Read pointer, load pointed byte into accumulator, then increment pointer.
// - Indirect destination: read pointer, store at it, then increment pointer.
// - Indirect destination stores the accumulator.
// - Both indirect forms only for the indirect move; two bytes long.
// - Interrupt entry spends 13 cycles before executing at the vector.
// - One extra cycle when instruction bytes cross a 256-byte flash page.
// - Index register is eight bits and offsets every indexed mode.
module oam_core
  import oam_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  // Program flash fetch
  output logic [15:0]      o_pc,
  input  wire logic [7:0]  i_flash_data,
  // Data RAM and register space
  output oam_mem_t         o_mem,
  input  wire logic [7:0]  i_mem_rdata,
  // Core register values
  input  wire logic [7:0]  i_index,
  input  wire logic [7:0]  i_acc,
  output logic [7:0]       o_acc,
  output logic             o_acc_we,
  // Interrupt and status
  input  wire logic        i_irq,
  output logic             o_irq_ack,
  output logic             o_busy,
  output logic             o_illegal
);

  typedef enum logic [3:0]
  {
    ST_FETCH,
    ST_OPND1,
    ST_OPND2,
    ST_PAGE,
    ST_RD1,
    ST_RD2,
    ST_WR,
    ST_PTRINC,
    ST_IRQ
  } oam_state_t;

  oam_state_t state_r, state_nxt;
  oam_dec_t   dec;
  oam_dec_t   dec_r, dec_nxt;
  logic [7:0] opc_r, opc_nxt;
  logic [7:0] op1_r, op1_nxt;
  logic [7:0] op2_r, op2_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic [7:0] val_r, val_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic       cross_r, cross_nxt;
  oam_mem_t   mem_r, mem_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic       acc_we_r, acc_we_nxt;
  logic       ack_r, ack_nxt;
  logic       ill_r, ill_nxt;
  logic       busy_r, busy_nxt;
  logic [7:0] idx_addr;
  logic [7:0] dst_addr;
  logic [7:0] alu;
  logic [15:0] pc_inc;

  // Opcode decoder
  oam_decode u_decode
  (
    .i_opcode (opc_r),
    .o_dec    (dec)
  );

  // Eight-bit index offset, carry dropped
  assign idx_addr = 8'(op1_r + i_index);
  assign dst_addr = (dec_r.mode == OAM_MODE_DST_IDX_IMM) ? idx_addr : op1_r;
  assign pc_inc   = pc_r + 16'h0001;

  // Result of the operation on the immediate and the stored value
  always_comb
  begin
    case (dec_r.op)
      OAM_OP_ADD: alu = 8'(i_mem_rdata + op2_r);
      OAM_OP_SUB: alu = 8'(i_mem_rdata - op2_r);
      OAM_OP_AND: alu = i_mem_rdata & op2_r;
      OAM_OP_OR:  alu = i_mem_rdata | op2_r;
      OAM_OP_XOR: alu = i_mem_rdata ^ op2_r;
      default:    alu = op2_r;
    endcase
  end

  // Sequencer next state
  always_comb
  begin
    state_nxt  = state_r;
    dec_nxt    = dec_r;
    opc_nxt    = opc_r;
    op1_nxt    = op1_r;
    op2_nxt    = op2_r;
    ptr_nxt    = ptr_r;
    val_nxt    = val_r;
    pc_nxt     = pc_r;
    cnt_nxt    = cnt_r;
    cross_nxt  = cross_r;
    mem_nxt    = '0;
    acc_nxt    = acc_r;
    acc_we_nxt = 1'b0;
    ack_nxt    = 1'b0;
    ill_nxt    = 1'b0;
    case (state_r)
      ST_FETCH:
      begin
        if (i_irq)
        begin
          ack_nxt   = 1'b1;
          cnt_nxt   = 5'(`OAM_IRQ_CYCLES - 5'h01);
          state_nxt = ST_IRQ;
        end
        else
        begin
          opc_nxt   = i_flash_data;
          pc_nxt    = pc_inc;
          cross_nxt = pc_inc[`OAM_PAGE_BIT] != pc_r[`OAM_PAGE_BIT];
          state_nxt = ST_OPND1;
        end
      end
      ST_OPND1:
      begin
        dec_nxt = dec;
        op1_nxt = i_flash_data;
        pc_nxt  = pc_inc;
        if (pc_inc[`OAM_PAGE_BIT] != pc_r[`OAM_PAGE_BIT])
          cross_nxt = 1'b1;
        if (!dec.valid)
        begin
          ill_nxt   = 1'b1;
          state_nxt = ST_FETCH;
        end
        else if (dec.length == `OAM_LEN_THREE)
          state_nxt = ST_OPND2;
        else
          state_nxt = cross_r ? ST_PAGE : ST_RD1;
      end
      ST_OPND2:
      begin
        op2_nxt = i_flash_data;
        pc_nxt  = pc_inc;
        state_nxt = cross_r ? ST_PAGE : ST_RD1;
      end
      ST_PAGE:
        state_nxt = ST_RD1;
      ST_RD1:
      begin
        cross_nxt = 1'b0;
        mem_nxt.req = 1'b1;
        case (dec_r.mode)
          OAM_MODE_MEM_MEM:
            mem_nxt.addr = op2_r;
          OAM_MODE_SRC_IND_INC, OAM_MODE_DST_IND_INC:
            mem_nxt.addr = op1_r;
          default:
          begin
            mem_nxt.addr      = dst_addr;
            mem_nxt.reg_space = dec_r.reg_space;
          end
        endcase
        state_nxt = ST_RD2;
      end
      ST_RD2:
      begin
        case (dec_r.mode)
          OAM_MODE_SRC_IND_INC:
          begin
            ptr_nxt      = i_mem_rdata;
            mem_nxt.req  = 1'b1;
            mem_nxt.addr = i_mem_rdata;
            state_nxt    = ST_WR;
          end
          OAM_MODE_DST_IND_INC:
          begin
            ptr_nxt       = i_mem_rdata;
            mem_nxt.req   = 1'b1;
            mem_nxt.wr    = 1'b1;
            mem_nxt.addr  = i_mem_rdata;
            mem_nxt.wdata = i_acc;
            state_nxt     = ST_PTRINC;
          end
          OAM_MODE_MEM_MEM:
          begin
            val_nxt   = i_mem_rdata;
            state_nxt = ST_WR;
          end
          default:
          begin
            val_nxt   = alu;
            state_nxt = ST_WR;
          end
        endcase
      end
      ST_WR:
      begin
        if (dec_r.mode == OAM_MODE_SRC_IND_INC)
        begin
          acc_nxt    = i_mem_rdata;
          acc_we_nxt = 1'b1;
          state_nxt  = ST_PTRINC;
        end
        else
        begin
          mem_nxt.req       = 1'b1;
          mem_nxt.wr        = 1'b1;
          mem_nxt.addr      = (dec_r.mode == OAM_MODE_MEM_MEM) ? op1_r : dst_addr;
          mem_nxt.reg_space = (dec_r.mode == OAM_MODE_MEM_MEM) ? 1'b0 : dec_r.reg_space;
          mem_nxt.wdata     = val_r;
          state_nxt         = ST_FETCH;
        end
      end
      ST_PTRINC:
      begin
        mem_nxt.req   = 1'b1;
        mem_nxt.wr    = 1'b1;
        mem_nxt.addr  = op1_r;
        mem_nxt.wdata = 8'(ptr_r + 8'h01);
        state_nxt     = ST_FETCH;
      end
      ST_IRQ:
      begin
        if (cnt_r == 5'h01)
        begin
          pc_nxt    = `OAM_VECTOR_BASE;
          state_nxt = ST_FETCH;
        end
        cnt_nxt = 5'(cnt_r - 5'h01);
      end
      default:
        state_nxt = ST_FETCH;
    endcase
    busy_nxt = (state_nxt != ST_FETCH);
  end

  // Sequencer registers
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_r  <= ST_FETCH;
      dec_r    <= '0;
      opc_r    <= `OAM_RST_BYTE;
      op1_r    <= `OAM_RST_BYTE;
      op2_r    <= `OAM_RST_BYTE;
      ptr_r    <= `OAM_RST_BYTE;
      val_r    <= `OAM_RST_BYTE;
      pc_r     <= `OAM_RST_PC;
      cnt_r    <= 5'h00;
      cross_r  <= 1'b0;
      mem_r    <= '0;
      acc_r    <= `OAM_RST_BYTE;
      acc_we_r <= 1'b0;
      ack_r    <= 1'b0;
      ill_r    <= 1'b0;
      busy_r   <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      dec_r    <= dec_nxt;
      opc_r    <= opc_nxt;
      op1_r    <= op1_nxt;
      op2_r    <= op2_nxt;
      ptr_r    <= ptr_nxt;
      val_r    <= val_nxt;
      pc_r     <= pc_nxt;
      cnt_r    <= cnt_nxt;
      cross_r  <= cross_nxt;
      mem_r    <= mem_nxt;
      acc_r    <= acc_nxt;
      acc_we_r <= acc_we_nxt;
      ack_r    <= ack_nxt;
      ill_r    <= ill_nxt;
      busy_r   <= busy_nxt;
    end
  end

  // Outputs straight from flops
  assign o_pc      = pc_r;
  assign o_mem     = mem_r;
  assign o_acc     = acc_r;
  assign o_acc_we  = acc_we_r;
  assign o_irq_ack = ack_r;
  assign o_busy    = busy_r;
  assign o_illegal = ill_r;

endmodule : oam_core

// ### shared/oam_consts.svh
`ifndef OAM_CONSTS_SVH
`define OAM_CONSTS_SVH

// Instruction lengths in bytes
`define OAM_LEN_THREE      2'h3
`define OAM_LEN_TWO        2'h2
// Interrupt entry latency in core cycles
`define OAM_IRQ_CYCLES     5'h0D
// Program flash page size is 256 bytes: crossing toggles PC bit 8
`define OAM_PAGE_BIT       8
// Reset values and interrupt vector
`define OAM_RST_BYTE       8'h00
`define OAM_RST_PC         16'h0000
`define OAM_VECTOR_BASE    16'h0000

`endif

// ### shared/oam_pkg.sv
package oam_pkg;

  // Addressing modes handled by this block
  typedef enum logic [2:0]
  {
    OAM_MODE_NONE,
    OAM_MODE_DST_DIR_IMM,
    OAM_MODE_DST_IDX_IMM,
    OAM_MODE_MEM_MEM,
    OAM_MODE_SRC_IND_INC,
    OAM_MODE_DST_IND_INC
  } oam_mode_t;

  // Operation applied to the two sources
  typedef enum logic [2:0]
  {
    OAM_OP_COPY,
    OAM_OP_ADD,
    OAM_OP_SUB,
    OAM_OP_AND,
    OAM_OP_OR,
    OAM_OP_XOR
  } oam_op_t;

  // Decoded instruction carried from decoder to sequencer
  typedef struct packed
  {
    logic      valid;
    oam_mode_t mode;
    oam_op_t   op;
    logic      reg_space;
    logic [1:0] length;
  } oam_dec_t;

  // One data-space access request
  typedef struct packed
  {
    logic       req;
    logic       wr;
    logic       reg_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } oam_mem_t;

endpackage : oam_pkg

// ### src/oam_decode.sv
`timescale 1ns/100ps
`include "oam_consts.svh"

// Opcode to addressing-mode decoder
module oam_decode
  import oam_pkg::*;
(
  // Opcode in
  input  wire logic [7:0] i_opcode,
  // Decoded result
  output oam_dec_t        o_dec
);

  // Table of the opcodes using the five modes
  always_comb
  begin
    o_dec = '{valid: 1'b1, mode: OAM_MODE_DST_DIR_IMM, op: OAM_OP_ADD,
              reg_space: 1'b0, length: `OAM_LEN_THREE};
    case (i_opcode)
      8'h06: o_dec.op = OAM_OP_ADD;
      8'h07: o_dec.mode = OAM_MODE_DST_IDX_IMM;
      8'h16: o_dec.op = OAM_OP_SUB;
      8'h17:
      begin
        o_dec.op   = OAM_OP_SUB;
        o_dec.mode = OAM_MODE_DST_IDX_IMM;
      end
      8'h26: o_dec.op = OAM_OP_AND;
      8'h27:
      begin
        o_dec.op   = OAM_OP_AND;
        o_dec.mode = OAM_MODE_DST_IDX_IMM;
      end
      8'h2E: o_dec.op = OAM_OP_OR;
      8'h2F:
      begin
        o_dec.op   = OAM_OP_OR;
        o_dec.mode = OAM_MODE_DST_IDX_IMM;
      end
      8'h36: o_dec.op = OAM_OP_XOR;
      8'h37:
      begin
        o_dec.op   = OAM_OP_XOR;
        o_dec.mode = OAM_MODE_DST_IDX_IMM;
      end
      8'h50: o_dec.op = OAM_OP_COPY;
      8'h51:
      begin
        o_dec.op   = OAM_OP_COPY;
        o_dec.mode = OAM_MODE_DST_IDX_IMM;
      end
      8'h62:
      begin
        o_dec.op        = OAM_OP_COPY;
        o_dec.reg_space = 1'b1;
      end
      8'h63:
      begin
        o_dec.op        = OAM_OP_COPY;
        o_dec.reg_space = 1'b1;
        o_dec.mode      = OAM_MODE_DST_IDX_IMM;
      end
      // Memory-to-memory form exists only for the copy op
      8'h5F:
      begin
        o_dec.op   = OAM_OP_COPY;
        o_dec.mode = OAM_MODE_MEM_MEM;
      end
      // Indirect post-increment forms exist only for the indirect move
      8'h3E:
      begin
        o_dec.op     = OAM_OP_COPY;
        o_dec.mode   = OAM_MODE_SRC_IND_INC;
        o_dec.length = `OAM_LEN_TWO;
      end
      8'h3F:
      begin
        o_dec.op     = OAM_OP_COPY;
        o_dec.mode   = OAM_MODE_DST_IND_INC;
        o_dec.length = `OAM_LEN_TWO;
      end
      default:
      begin
        o_dec.valid  = 1'b0;
        o_dec.mode   = OAM_MODE_NONE;
        o_dec.length = `OAM_LEN_TWO;
      end
    endcase
  end

endmodule : oam_decode

// ### testbench/oam_core_props.sv
`timescale 1ns/100ps

// Port-level checks on the addressing core
module oam_core_props
  import oam_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  // Core ports watched
  input wire logic [15:0] o_pc,
  input wire oam_mem_t    o_mem,
  input wire logic [7:0]  i_mem_rdata,
  input wire logic        i_irq,
  input wire logic [7:0]  o_acc,
  input wire logic        o_acc_we,
  input wire logic        o_irq_ack,
  input wire logic        o_busy,
  input wire logic        o_illegal
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  // Opcode bytes come from successive flash addresses
  property p_pc_step;
    !o_busy && !i_irq |=> o_pc == $past(o_pc) + 16'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("pc did not step after opcode fetch");

  property p_fetch_busy;
    !o_busy && !i_irq |-> ##1 o_busy;
  endproperty
  a_fetch_busy: assert property (p_fetch_busy)
    else $error("core idle after opcode fetch");

  // Interrupt entry
  property p_irq_take;
    !o_busy && i_irq |=> o_irq_ack && o_busy;
  endproperty
  a_irq_take: assert property (p_irq_take)
    else $error("interrupt not accepted at fetch");

  property p_irq_hold;
    $rose(o_irq_ack) |-> o_busy [*8];
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt entry ended early");

  property p_irq_vec;
    o_irq_ack |-> ##11 o_busy ##1 (o_pc == 16'h0000 && !o_busy);
  endproperty
  a_irq_vec: assert property (p_irq_vec)
    else $error("vector not reached after interrupt");

  // Accumulator loads follow a data read
  property p_acc_pulse;
    o_acc_we |=> !o_acc_we;
  endproperty
  a_acc_pulse: assert property (p_acc_pulse)
    else $error("accumulator write longer than one cycle");

  property p_acc_src;
    o_acc_we |-> o_acc == $past(i_mem_rdata) && $past(o_mem.req) && !$past(o_mem.wr);
  endproperty
  a_acc_src: assert property (p_acc_src)
    else $error("accumulator value not the byte read");

  property p_illegal_quiet;
    o_illegal |-> !o_mem.req && !o_acc_we;
  endproperty
  a_illegal_quiet: assert property (p_illegal_quiet)
    else $error("unknown opcode caused an access");

  // Main scenarios reached
  c_irq: cover property (o_irq_ack);
  c_acc: cover property (o_acc_we);
  c_illegal: cover property (o_illegal);
endmodule : oam_core_props

// ### testbench/oam_mem_model.sv
`timescale 1ns/100ps

// Flash, data RAM, register space and accumulator beside the core
module oam_mem_model
  import oam_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_pc,
  input  wire oam_mem_t    i_mem,
  input  wire logic [7:0]  i_acc_new,
  input  wire logic        i_acc_we,
  output logic [7:0]       o_flash_data,
  output logic [7:0]       o_rdata,
  output logic [7:0]       o_acc
);
  logic [7:0] flash [0:511];
  logic [7:0] ram   [0:255];
  logic [7:0] regs  [0:255];
  logic [7:0] word;

  // Flash answers in the same cycle
  assign o_flash_data = flash[i_pc[8:0]];
  // Data is only valid while a request is up
  assign word         = i_mem.reg_space ? regs[i_mem.addr] : ram[i_mem.addr];
  assign o_rdata      = i_mem.req ? word : ~word;

  // Writes and accumulator updates land at the edge
  always @(posedge i_clk_sys)
  begin
    if (i_mem.req && i_mem.wr && i_mem.reg_space)
      regs[i_mem.addr] <= i_mem.wdata;
    else if (i_mem.req && i_mem.wr)
      ram[i_mem.addr] <= i_mem.wdata;
    if (i_acc_we)
      o_acc <= i_acc_new;
  end
endmodule : oam_mem_model

// ### testbench/tb.sv
`timescale 1ns/100ps

// Self-checking bench for the addressing core
module tb
  import oam_pkg::*;
();
  logic        i_clk_sys;
  logic        i_reset;
  logic        i_irq;
  logic [7:0]  i_index;
  logic [15:0] o_pc;
  logic [7:0]  flash_data;
  oam_mem_t    o_mem;
  logic [7:0]  mem_rdata;
  logic [7:0]  acc;
  logic [7:0]  o_acc;
  logic        o_acc_we;
  logic        o_irq_ack;
  logic        o_busy;
  logic        o_illegal;
  int          n_errors;
  int          cmp_count;
  int          cyc;
  int          n_ill;
  int          n_ack;
  int          n_plain;
  int          n;

  oam_core DUT (.i_clk_sys, .i_reset, .o_pc, .i_flash_data(flash_data), .o_mem,
    .i_mem_rdata(mem_rdata), .i_index, .i_acc(acc), .o_acc, .o_acc_we, .i_irq,
    .o_irq_ack, .o_busy, .o_illegal);

  oam_mem_model u_mem (.i_clk_sys, .i_pc(o_pc), .i_mem(o_mem), .i_acc_new(o_acc),
    .i_acc_we(o_acc_we), .o_flash_data(flash_data), .o_rdata(mem_rdata), .o_acc(acc));

  // Clock
  always #2 i_clk_sys = ~i_clk_sys;

  // Pulse counters and run ceiling
  always @(posedge i_clk_sys)
  begin
    cyc <= cyc + 1;
    if (o_illegal === 1'b1)
      n_ill <= n_ill + 1;
    if (o_irq_ack === 1'b1)
      n_ack <= n_ack + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : check

  task automatic stop_test;
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // Idle at fetch on the given address
  task automatic wait_fetch(input logic [15:0] pc);
    int k;
    k = 0;
    while (!(o_pc === pc && o_busy === 1'b0) && k < 2000)
    begin
      @(negedge i_clk_sys);
      k++;
    end
    check({15'h0000, k < 2000}, 16'h0001, "fetch address not reached");
  endtask : wait_fetch

  // Cycles of one instruction, irq level set from its fetch edge
  task automatic measure(input logic irq_v, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge i_clk_sys) i_irq <= irq_v;
      @(negedge i_clk_sys);
      cnt++;
    end while (o_busy === 1'b1 && cnt < 64);
  endtask : measure

  // Program: dir-imm add, idx-imm add, reg copy, mem copy, two indirect moves,
  // two unknown opcodes, the other ops, copy filler, then an add spanning a flash page
  task automatic load;
    logic [7:0] prog [38];
    prog = '{8'h06, 8'h10, 8'h05, 8'h07, 8'hF0, 8'h03, 8'h62, 8'h08, 8'h06, 8'h5F,
             8'h30, 8'h31, 8'h3E, 8'h40, 8'h3F, 8'h41, 8'h01, 8'h00, 8'h01, 8'h00,
             8'h16, 8'hE1, 8'h01, 8'h27, 8'hC2, 8'h0F, 8'h2E, 8'hE3, 8'h05, 8'h37,
             8'hC4, 8'hFF, 8'h51, 8'hC5, 8'h99, 8'h63, 8'hC6, 8'h5A};
    for (int i = 0; i < 256; i++)
    begin
      u_mem.ram[i]  = 8'h00;
      u_mem.regs[i] = 8'h00;
    end
    for (int i = 0; i < 38; i++)
      u_mem.flash[i] = prog[i];
    for (int i = 38; i < 254; i += 3)
    begin
      u_mem.flash[i]     = 8'h50;
      u_mem.flash[i + 1] = 8'hE0;
      u_mem.flash[i + 2] = 8'h00;
    end
    u_mem.flash[254] = 8'h06;
    u_mem.flash[255] = 8'h11;
    u_mem.flash[256] = 8'h01;
    u_mem.ram[8'h10] = 8'h20;
    u_mem.ram[8'h11] = 8'h40;
    u_mem.ram[8'h31] = 8'hAA;
    u_mem.ram[8'hE1] = 8'h10;
    u_mem.ram[8'hE2] = 8'h3C;
    u_mem.ram[8'hE3] = 8'h30;
    u_mem.ram[8'hE4] = 8'h55;
    u_mem.regs[8'h30] = 8'h33;
    u_mem.ram[8'h40] = 8'hFF;
    u_mem.ram[8'hFF] = 8'h77;
    u_mem.ram[8'h41] = 8'h50;
    u_mem.o_acc = 8'h00;
  endtask : load

  task automatic t_direct;
    wait_fetch(16'h0000);
    measure(1'b0, n_plain);
    check(16'(n_plain), 16'h0006, "three-byte cycles");
    @(negedge i_clk_sys);
    check({8'h00, u_mem.ram[8'h10]}, {8'h00, 8'h20 + 8'h05}, "direct add");
  endtask : t_direct

  task automatic t_indexed;
    wait_fetch(16'h0006);
    @(negedge i_clk_sys);
    check({8'h00, u_mem.ram[8'h10]}, 16'h0028, "indexed add wrap");
  endtask : t_indexed

  task automatic t_regspace;
    wait_fetch(16'h0009);
    @(negedge i_clk_sys);
    check({u_mem.regs[8'h08], u_mem.ram[8'h08]}, 16'h0600, "register copy");
  endtask : t_regspace

  task automatic t_copy;
    wait_fetch(16'h000C);
    @(negedge i_clk_sys);
    check({u_mem.ram[8'h30], u_mem.regs[8'h30]}, 16'hAA33, "memory copy");
  endtask : t_copy

  task automatic t_src_ind;
    wait_fetch(16'h000E);
    @(negedge i_clk_sys);
    check({acc, u_mem.ram[8'h40]}, 16'h7700, "indirect load");
  endtask : t_src_ind

  task automatic t_dst_ind;
    wait_fetch(16'h0010);
    @(negedge i_clk_sys);
    check({u_mem.ram[8'h50], u_mem.ram[8'h41]}, 16'h7751, "indirect store");
  endtask : t_dst_ind

  task automatic t_illegal;
    wait_fetch(16'h0012);
    check({15'h0000, o_illegal}, 16'h0001, "unknown opcode flag");
    @(negedge i_clk_sys);
    check(16'(n_ill), 16'h0001, "unknown opcode pulse");
  endtask : t_illegal

  // Sub, and, or, xor and the indexed copies
  task automatic t_ops;
    wait_fetch(16'h0026);
    @(negedge i_clk_sys);
    check({u_mem.ram[8'hE1], u_mem.ram[8'hE2]}, 16'h0F0C, "sub/and ops");
    check({u_mem.ram[8'hE3], u_mem.ram[8'hE4]}, 16'h35AA, "or/xor ops");
    check({u_mem.ram[8'hE5], u_mem.regs[8'hE6]}, 16'h995A, "indexed copies");
  endtask : t_ops

  task automatic t_cross;
    wait_fetch(16'h00FE);
    measure(1'b1, n);
    check(16'(n), 16'(n_plain + 1), "page crossing cycles");
    check({o_mem.addr, o_mem.wdata}, 16'h1141, "add across page");
    check({14'h0000, o_mem.req, o_mem.wr}, 16'h0003, "write across page");
  endtask : t_cross

  task automatic t_irq;
    measure(1'b0, n);
    check(16'(n), 16'h000D, "interrupt entry cycles");
    check({o_pc[7:0], 8'(n_ack)}, 16'h0001, "interrupt vector");
    check({8'h00, u_mem.ram[8'h11]}, 16'h0041, "page add stored");
  endtask : t_irq

  // Main sequence
  initial
  begin
    i_clk_sys = 1'b0;
    i_reset   = 1'b1;
    i_irq     = 1'b0;
    i_index   = 8'h20;
    n_errors  = 0;
    cmp_count = 0;
    cyc       = 0;
    n_ill     = 0;
    n_ack     = 0;
    load();
    repeat (4) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    t_direct();
    t_indexed();
    t_regspace();
    t_copy();
    t_src_ind();
    t_dst_ind();
    t_illegal();
    t_ops();
    t_cross();
    t_irq();
    stop_test();
  end
endmodule : tb

bind oam_core oam_core_props u_props (.i_clk_sys, .i_reset, .o_pc, .o_mem, .i_mem_rdata,
  .i_irq, .o_acc, .o_acc_we, .o_irq_ack, .o_busy, .o_illegal);
